// ===== design/cuc_pkg.sv
// Package with register map, field layouts and timing constants of the calendar and uptime clock.
//////////////////////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RQ1 - Seven calendar bytes at indices zero to six.
// RQ2 - Calendar values held as two decimal digits.
// RQ3 - Calendar fields stay within their decimal limits.
// RQ4 - Weekday counts zero Sunday to six Saturday.
// RQ5 - Write stores byte into the selected field.
// RQ6 - Calendar keeps counting without bus activity.
// RQ7 - Four uptime values at indices ten to thirteen.
// RQ8 - Seconds tick each second, carry into minutes.
// RQ9 - Minutes reaching sixty carry into hours.
// RQ10 - Hours are sixteen bits and wrap.
// RQ11 - Total seconds count independently and wrap.
// RQ12 - Uptime values clear to zero at reset.
// RQ13 - Uptime values are plain binary counts.
// RQ14 - Seconds and minutes return to zero on carry.
// RQ15 - Calendar carries decimally; weekday follows date.
//////////////////////////////////////////////////////////////////////////////////////////////////
package cuc_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam logic [3:0] IDX_CAL_SEC = 4'h0;
  localparam logic [3:0] IDX_CAL_MIN = 4'h1;
  localparam logic [3:0] IDX_CAL_HOUR = 4'h2;
  localparam logic [3:0] IDX_CAL_DATE = 4'h3;
  localparam logic [3:0] IDX_CAL_WDAY = 4'h4;
  localparam logic [3:0] IDX_CAL_MON = 4'h5;
  localparam logic [3:0] IDX_CAL_YEAR = 4'h6;
  localparam logic [3:0] IDX_UP_SEC = 4'ha;
  localparam logic [3:0] IDX_UP_MIN = 4'hb;
  localparam logic [3:0] IDX_UP_HOUR = 4'hc;
  localparam logic [3:0] IDX_UP_TOTAL = 4'hd;
  localparam int unsigned ADDR_LSB = 2;
  localparam int unsigned ADDR_W = 6;
  localparam logic [7:0] CAL_SEC_MAX = 8'h59;
  localparam logic [7:0] CAL_MIN_MAX = 8'h59;
  localparam logic [7:0] CAL_HOUR_MAX = 8'h23;
  localparam logic [7:0] CAL_DATE_MAX = 8'h31;
  localparam logic [7:0] CAL_DATE_MIN = 8'h01;
  localparam logic [7:0] CAL_WDAY_MAX = 8'h06;
  localparam logic [7:0] CAL_MON_MAX = 8'h12;
  localparam logic [7:0] CAL_MON_MIN = 8'h01;
  localparam logic [7:0] CAL_YEAR_MAX = 8'h99;
  localparam logic [7:0] CAL_SEC_RST = 8'h00;
  localparam logic [7:0] CAL_MIN_RST = 8'h00;
  localparam logic [7:0] CAL_HOUR_RST = 8'h00;
  localparam logic [7:0] CAL_DATE_RST = 8'h01;
  localparam logic [7:0] CAL_WDAY_RST = 8'h00;
  localparam logic [7:0] CAL_MON_RST = 8'h01;
  localparam logic [7:0] CAL_YEAR_RST = 8'h00;
  localparam logic [7:0] UP_MINSEC_TOP = 8'd59;
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] wday;
    logic [7:0] mon;
    logic [7:0] year;
  } cuc_cal_t;
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [15:0] hour;
    logic [15:0] total;
  } cuc_up_t;
endpackage

// ===== design/cuc_clock.sv
// Calendar and uptime clock with an APB register slave.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
module cuc_clock #(
  parameter int unsigned TICK_CYCLES = cuc_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Once-a-second strobe.
  output logic sec_tick
);
  //////////////////////////////////////////////////////////////////////////////
  logic [31:0] tick_cnt_q;
  logic tick;
  logic wr_en;
  logic [3:0] idx;
  logic idx_ok;
  logic [7:0] wb;
  logic [15:0] wh;
  cuc_pkg::cuc_cal_t cal_q;
  cuc_pkg::cuc_up_t up_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  // Inc of a two-digit decimal byte; the units digit rolls at nine.
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] >= 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // Last date of the month; leap years follow the two-digit year.
  function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
    logic [7:0] r;
    logic [7:0] bin;
    r = 8'h31;
    bin = ({4'h0, yr[7:4]} * 8'h0a) + {4'h0, yr[3:0]};
    case (mon)
      8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
      8'h02: r = (bin[1:0] == 2'b00) ? 8'h29 : 8'h28;
      default: r = 8'h31;
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Tick source. Free-running so time keeps moving with no bus traffic.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= 32'h0;
    end else if (tick) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1; // RQ6
    end
  end
  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= tick;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode. Zero-wait slave: the access phase completes in one cycle.
  assign idx = paddr[cuc_pkg::ADDR_LSB +: 4];
  assign idx_ok = (paddr[31:cuc_pkg::ADDR_LSB + 4] == '0) && (paddr[1:0] == 2'b00) &&
                  ((idx <= cuc_pkg::IDX_CAL_YEAR) ||
                   ((idx >= cuc_pkg::IDX_UP_SEC) && (idx <= cuc_pkg::IDX_UP_TOTAL)));
  assign wr_en = psel && penable && pwrite && idx_ok;
  assign wb = pstrb[0] ? pwdata[7:0] : 8'h00;
  assign wh = {pstrb[1] ? pwdata[15:8] : 8'h00, wb};
  assign pready = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // Calendar. A bus write wins over a tick in the same cycle.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_q.sec <= cuc_pkg::CAL_SEC_RST;
      cal_q.min <= cuc_pkg::CAL_MIN_RST;
      cal_q.hour <= cuc_pkg::CAL_HOUR_RST;
      cal_q.date <= cuc_pkg::CAL_DATE_RST;
      cal_q.wday <= cuc_pkg::CAL_WDAY_RST;
      cal_q.mon <= cuc_pkg::CAL_MON_RST;
      cal_q.year <= cuc_pkg::CAL_YEAR_RST;
    end else if (wr_en && (idx <= cuc_pkg::IDX_CAL_YEAR)) begin
      case (idx) // RQ1
        cuc_pkg::IDX_CAL_SEC: cal_q.sec <= wb; // RQ5
        cuc_pkg::IDX_CAL_MIN: cal_q.min <= wb;
        cuc_pkg::IDX_CAL_HOUR: cal_q.hour <= wb;
        cuc_pkg::IDX_CAL_DATE: cal_q.date <= wb;
        cuc_pkg::IDX_CAL_WDAY: cal_q.wday <= wb;
        cuc_pkg::IDX_CAL_MON: cal_q.mon <= wb;
        default: cal_q.year <= wb;
      endcase
    end else if (tick) begin
      // Software-written values outside range still roll at the limit.
      if (cal_q.sec < cuc_pkg::CAL_SEC_MAX) begin
        cal_q.sec <= bcd_inc(cal_q.sec); // RQ2
      end else begin
        cal_q.sec <= 8'h00; // RQ3
        if (cal_q.min < cuc_pkg::CAL_MIN_MAX) begin
          cal_q.min <= bcd_inc(cal_q.min); // RQ15
        end else begin
          cal_q.min <= 8'h00;
          if (cal_q.hour < cuc_pkg::CAL_HOUR_MAX) begin
            cal_q.hour <= bcd_inc(cal_q.hour);
          end else begin
            cal_q.hour <= 8'h00;
            cal_q.wday <= (cal_q.wday >= cuc_pkg::CAL_WDAY_MAX) ? 8'h00 :
                          bcd_inc(cal_q.wday); // RQ4
            if (cal_q.date < month_last(cal_q.mon, cal_q.year)) begin
              cal_q.date <= bcd_inc(cal_q.date);
            end else begin
              cal_q.date <= cuc_pkg::CAL_DATE_MIN;
              if (cal_q.mon < cuc_pkg::CAL_MON_MAX) begin
                cal_q.mon <= bcd_inc(cal_q.mon);
              end else begin
                cal_q.mon <= cuc_pkg::CAL_MON_MIN;
                cal_q.year <= (cal_q.year >= cuc_pkg::CAL_YEAR_MAX) ? 8'h00 :
                              bcd_inc(cal_q.year);
              end
            end
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Uptime seconds, minutes and hours chain; plain binary.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      up_q.sec <= 8'h00; // RQ12
      up_q.min <= 8'h00;
      up_q.hour <= 16'h0000;
    end else if (wr_en && (idx == cuc_pkg::IDX_UP_SEC)) begin
      up_q.sec <= wb; // RQ7
    end else if (wr_en && (idx == cuc_pkg::IDX_UP_MIN)) begin
      up_q.min <= wb;
    end else if (wr_en && (idx == cuc_pkg::IDX_UP_HOUR)) begin
      up_q.hour <= wh; // RQ13
    end else if (tick) begin
      if (up_q.sec < cuc_pkg::UP_MINSEC_TOP) begin
        up_q.sec <= up_q.sec + 8'h01; // RQ8
      end else begin
        up_q.sec <= 8'h00; // RQ14
        if (up_q.min < cuc_pkg::UP_MINSEC_TOP) begin
          up_q.min <= up_q.min + 8'h01;
        end else begin
          up_q.min <= 8'h00;
          up_q.hour <= up_q.hour + 16'h0001; // RQ9 RQ10
        end
      end
    end
  end

  // Total seconds run on their own; a write elsewhere never disturbs them.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      up_q.total <= 16'h0000; // RQ12
    end else if (wr_en && (idx == cuc_pkg::IDX_UP_TOTAL)) begin
      up_q.total <= wh;
    end else if (tick) begin
      up_q.total <= up_q.total + 16'h0001; // RQ11
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data and error, registered at the setup phase.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= !idx_ok;
      case (idx)
        cuc_pkg::IDX_CAL_SEC: prdata_q <= {24'h0, cal_q.sec};
        cuc_pkg::IDX_CAL_MIN: prdata_q <= {24'h0, cal_q.min};
        cuc_pkg::IDX_CAL_HOUR: prdata_q <= {24'h0, cal_q.hour};
        cuc_pkg::IDX_CAL_DATE: prdata_q <= {24'h0, cal_q.date};
        cuc_pkg::IDX_CAL_WDAY: prdata_q <= {24'h0, cal_q.wday};
        cuc_pkg::IDX_CAL_MON: prdata_q <= {24'h0, cal_q.mon};
        cuc_pkg::IDX_CAL_YEAR: prdata_q <= {24'h0, cal_q.year};
        cuc_pkg::IDX_UP_SEC: prdata_q <= {24'h0, up_q.sec};
        cuc_pkg::IDX_UP_MIN: prdata_q <= {24'h0, up_q.min};
        cuc_pkg::IDX_UP_HOUR: prdata_q <= {16'h0, up_q.hour};
        cuc_pkg::IDX_UP_TOTAL: prdata_q <= {16'h0, up_q.total};
        default: prdata_q <= 32'h0;
      endcase
      if (!idx_ok) begin
        prdata_q <= 32'h0;
      end
    end
  end
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
endmodule

// ===== verification/cuc_clock_assertions.sv
// Port checker of the calendar and uptime clock.
`timescale 1ns/10ps
module cuc_clock_chk #(
  parameter int unsigned TICK_CYCLES = 100
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Second strobe.
  input wire logic sec_tick
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire rd = psel && !penable && !pwrite;
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_pulse; sec_tick |=> !sec_tick; endproperty
  a_pulse: assert property (p_pulse) else $error("tick too long");
  property p_period; sec_tick |-> ##TICK_CYCLES sec_tick; endproperty
  a_period: assert property (p_period) else $error("tick period wrong");
  property p_unmap; rd && paddr == 32'h1c |=> pslverr && prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
  property p_upsec; rd && paddr == 32'h28 |=> !pslverr && prdata < 32'd60; endproperty
  a_upsec: assert property (p_upsec) else $error("seconds out of range");
  property p_bcd;
    rd && paddr < 32'h1c && paddr[1:0] == 2'h0 |=>
      prdata[31:8] == 24'h0 && prdata[3:0] <= 4'h9 && prdata[7:4] <= 4'h9;
  endproperty
  a_bcd: assert property (p_bcd) else $error("calendar not decimal");
  property p_wday; rd && paddr == 32'h10 |=> prdata <= 32'h6; endproperty
  a_wday: assert property (p_wday) else $error("weekday out of range");
  property p_wide; rd && paddr[31:3] == 29'h6 |=> prdata[31:16] == 16'h0; endproperty
  a_wide: assert property (p_wide) else $error("wide value too wide");
  cover property (sec_tick);
  cover property (rd && paddr == 32'h1c);
  cover property (psel && penable && pwrite && paddr == 32'h34);
endmodule
bind cuc_clock cuc_clock_chk #(.TICK_CYCLES(TICK_CYCLES)) cuc_clock_chk_i (
  .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sec_tick(sec_tick));

// ===== verification/cuc_clock_bench.sv
// Self-checking bench of the calendar and uptime clock.
`timescale 1ns/10ps
module cuc_clock_bench;
  // A short second keeps the run brief; each access_all pass, and each write-then-read pair, fits in one tick window.
  localparam int unsigned TICKS = 100;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sec_tick;
  logic [31:0] r;
  logic e;
  logic [31:0] v [0:13];
  int n_fail = 0;
  int check_count = 0;
  int seed = 32'h756d412b;
  always #2.5 core_clk = ~core_clk;
  cuc_clock #(.TICK_CYCLES(TICKS)) cuc_clock_i (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sec_tick(sec_tick));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input int idx, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= idx * 4;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic sync();
    do @(posedge core_clk); while (sec_tick !== 1'b1);
  endtask
  task automatic access_all(input logic w);
    for (int i = 0; i < 14; i++) begin
      if (i < 7 || i > 9) begin
        apb(i, w, v[i]);
        if (!w) check(r, v[i]);
        check({31'h0, e}, 32'h0);
      end
    end
  endtask
  function automatic logic [31:0] rnd(int n);
    return $unsigned($random(seed)) % n;
  endfunction
  function automatic logic [31:0] bcd(logic [31:0] x);
    return ((x / 10) << 4) | (x % 10);
  endfunction
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    v = '{default: 32'h0};
    v[3] = 32'h1;
    v[5] = 32'h1;
    access_all(1'b0);
    $display("reset values done");
    sync();
    v = '{32'h59, 32'h59, 32'h23, 32'h31, 32'h6, 32'h12, 32'h99, 32'h0, 32'h0, 32'h0,
      32'd59, 32'd59, 32'hffff, 32'hffff};
    access_all(1'b1);
    sync();
    v = '{default: 32'h0};
    v[3] = 32'h1;
    v[5] = 32'h1;
    access_all(1'b0);
    $display("rollover done");
    for (int k = 0; k < 4; k++) begin
      v = '{bcd(rnd(59)), bcd(rnd(60)), bcd(rnd(24)), bcd(rnd(28) + 1), rnd(7),
        bcd(rnd(12) + 1), bcd(rnd(100)), 32'h0, 32'h0, 32'h0, rnd(60), rnd(60),
        rnd(65536), rnd(65536)};
      if (k == 0) v[0] = 32'h09;
      sync();
      access_all(1'b1);
      access_all(1'b0);
      sync();
      v[0] = (v[0][3:0] == 4'h9) ? v[0] + 32'h7 : v[0] + 32'h1;
      if (v[10] == 32'd59 && v[11] == 32'd59) v[12] = (v[12] + 32'h1) & 32'hffff;
      if (v[10] == 32'd59) v[11] = (v[11] == 32'd59) ? 32'h0 : v[11] + 32'h1;
      v[10] = (v[10] == 32'd59) ? 32'h0 : v[10] + 32'h1;
      v[13] = (v[13] + 32'h1) & 32'hffff;
      access_all(1'b0);
    end
    $display("random counting done");
    sync();
    pstrb <= 4'h1;
    apb(13, 1'b1, 32'habcd);
    pstrb <= 4'hf;
    apb(13, 1'b0, 32'h0);
    check(r, 32'hcd);
    $display("byte strobes done");
    for (int i = 7; i < 16; i++) begin
      if (i < 10 || i > 13) begin
        apb(i, 1'b1, 32'h55);
        apb(i, 1'b0, 32'h0);
        check(r, 32'h0);
        check({31'h0, e}, 32'h1);
      end
    end
    $display("unmapped done");
    tally_and_finish();
  end
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
endmodule
